// File: rtl/cssc_top.sv
// current sense control, track-and-hold, prewarning and channel state logic
//
// Function
// R1: with track-and-hold selected the sense output keeps being driven after the channel turns off.
// R2: after turn-on the sense is valid only once the sync output falls, in either mode.
// R3: at switch-off in track-and-hold the last sense value is held and sync goes high.
// R4: changing the sensed channel in track-and-hold discards the held value and reacquires it.
// R5: the controller should not use track-and-hold below 60 Hz switching.
// R6: a per-channel offset polarity bit at D8 of the retry config adds (1) or subtracts (0) the offset.
// R7: the held value keeps the polarity active at switch-off; later changes do not alter it.
// R8: the controller must switch on once with opposite polarity before the second measurement.
// R9: the controller spaces its two measurements about five filter time constants apart.
// R10: in normal mode the prewarning flag sets above threshold without turning the channel off.
// R11: the prewarning flag clears only on a fault report read while the temperature is below threshold.
// R12: the channel state bits show each channel's on state in real time.
// R13: in synchronous mode the sense output stops presenting current once the channel is off.
// R14: two sense select bits choose channel 0, channel 1 or temperature as sense source.
// R15: comparator levels are synchronised, and clear-on-read acts at the end of the read.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module cssc_top
  import cssc_pkg::*;
#(
  parameter int SENSE_W = 10
)(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  // register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [15:0]        reg_rdata,
  // channel and comparator inputs
  input  wire logic [1:0]         chan_on_cmd,
  input  wire logic [1:0]         out_above_half,
  input  wire logic               temp_above_prewarn,
  input  wire logic               normal_mode,
  input  wire logic [SENSE_W-1:0] chan0_sense,
  input  wire logic [SENSE_W-1:0] chan1_sense,
  input  wire logic [SENSE_W-1:0] temp_sense,
  input  wire logic [SENSE_W-1:0] chan0_offset,
  input  wire logic [SENSE_W-1:0] chan1_offset,
  // sense outputs
  output logic      [SENSE_W-1:0] sense_out,
  output logic                    sense_drive,
  output logic                    sense_sync,
  output logic                    irq
);
  // ************************************************************
  // registers and state
  // ************************************************************
  logic [15:0]        general_config_reg_q;
  logic [1:0]         channel_offset_polarity_q;
  logic               temp_prewarn_flag_q;
  logic [IRQ_WIDTH-1:0] irq_status_q;
  logic [IRQ_WIDTH-1:0] irq_mask_q;
  logic [SENSE_W-1:0] held_q;
  logic [1:0]         src_q;
  logic [1:0]         on_prev_q;
  logic [7:0]         cnt_q;
  cssc_sense_e        st_q;
  cssc_sense_e        st_d;
  logic [7:0]         cnt_d;
  logic [SENSE_W-1:0] held_d;
  logic               read_pend_q;

  // ************************************************************
  // synchronised comparator levels
  // ************************************************************
  logic [2:0] cmp_sync;
  cssc_sync #(.WIDTH(3)) u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in ({temp_above_prewarn, out_above_half}),
    .sync_out (cmp_sync)                            // R15
  );
  wire [1:0] chan_state  = cmp_sync[1:0];           // R12
  wire       temp_over   = cmp_sync[2];

  // ************************************************************
  // decode
  // ************************************************************
  wire       wr_gcr    = reg_wr && (reg_addr == ADDR_GENERAL_CONFIG);
  wire       wr_retry  = reg_wr && (reg_addr == ADDR_RETRY_CONFIG);
  wire       wr_stat   = reg_wr && (reg_addr == ADDR_IRQ_STATUS);
  wire       wr_mask   = reg_wr && (reg_addr == ADDR_IRQ_MASK);
  wire       rd_fault  = reg_rd && (reg_addr == ADDR_FAULT_REPORT);
  wire       track_hold = general_config_reg_q[GCR_TRACK_HOLD_BIT];
  wire [1:0] src_sel   = {general_config_reg_q[GCR_SENSE_HI_BIT],
                          general_config_reg_q[GCR_SENSE_LO_BIT]}; // R14
  wire       src_is_ch = (src_sel == SRC_CH0) || (src_sel == SRC_CH1);
  wire       ch_idx    = (src_sel == SRC_CH1);
  wire       ch_on     = src_is_ch && chan_on_cmd[ch_idx];
  wire       ch_rise   = ch_on && !on_prev_q[ch_idx];
  wire       ch_fall   = src_is_ch && !chan_on_cmd[ch_idx] && on_prev_q[ch_idx];
  wire       src_chg   = (src_sel != src_q);

  // offset added or subtracted per channel polarity
  wire [SENSE_W-1:0] raw_sense = ch_idx ? chan1_sense : chan0_sense;
  wire [SENSE_W-1:0] raw_off   = ch_idx ? chan1_offset : chan0_offset;
  wire [SENSE_W-1:0] live_sense = channel_offset_polarity_q[ch_idx]
                                  ? SENSE_W'(raw_sense + raw_off)
                                  : SENSE_W'(raw_sense - raw_off);  // R6

  // ************************************************************
  // sense path state machine
  // ************************************************************
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    held_d = held_q;
    case (st_q)
      ST_IDLE:
      begin
        if (ch_on)
        begin
          st_d  = ST_SETTLE;
          cnt_d = 8'(SETTLE_CYCLES);
        end
      end
      ST_SETTLE:
      begin
        if (src_chg || !ch_on)
        begin
          st_d = ST_IDLE;
        end
        else if (cnt_q <= 8'h01)
        begin
          st_d = ST_VALID;                          // R2
        end
        else
        begin
          cnt_d = 8'(cnt_q - 8'h01);
        end
      end
      ST_VALID:
      begin
        if (src_chg)
        begin
          st_d = ST_IDLE;                           // R4
        end
        else if (ch_fall && track_hold)
        begin
          st_d   = ST_HOLD;                         // R3
          held_d = live_sense;                      // R7
        end
        else if (ch_fall)
        begin
          st_d = ST_IDLE;                           // R13
        end
        else
        begin
          held_d = live_sense;
        end
      end
      ST_HOLD:
      begin
        if (src_chg || !track_hold)
        begin
          st_d = ST_IDLE;                           // R4
        end
        else if (ch_rise)
        begin
          st_d  = ST_SETTLE;
          cnt_d = 8'(SETTLE_CYCLES);
        end
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // sense state registers
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      st_q      <= ST_IDLE;
      cnt_q     <= 8'h00;
      held_q    <= '0;
      src_q     <= SRC_NONE;
      on_prev_q <= 2'h0;
    end
    else
    begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      held_q    <= src_chg ? '0 : held_d;           // R4
      src_q     <= src_sel;
      on_prev_q <= chan_on_cmd;
    end
  end

  // ************************************************************
  // sense outputs
  // ************************************************************
  wire sense_live = (src_sel == SRC_TEMP) || (st_q == ST_VALID) || (st_q == ST_SETTLE);
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      sense_out   <= '0;
      sense_drive <= 1'b0;
      sense_sync  <= 1'b1;
    end
    else
    begin
      sense_drive <= sense_live || (st_q == ST_HOLD);  // R1
      sense_out   <= (src_sel == SRC_TEMP) ? temp_sense :
                     (st_q == ST_HOLD)     ? held_q :
                     sense_live            ? live_sense : '0;
      sense_sync  <= (st_q != ST_VALID);            // R2
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      general_config_reg_q      <= GENERAL_CONFIG_RST;
      channel_offset_polarity_q <= 2'h0;
      irq_mask_q                <= IRQ_MASK_RST;
    end
    else
    begin
      if (wr_gcr)
        general_config_reg_q <= reg_wdata;
      if (wr_retry)
        channel_offset_polarity_q[ch_idx] <= reg_wdata[RETRY_OFFSET_BIT]; // R6
      if (wr_mask)
        irq_mask_q <= reg_wdata[IRQ_WIDTH-1:0];
    end
  end

  // ************************************************************
  // prewarning flag, cleared after the read completes
  // ************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      temp_prewarn_flag_q <= 1'b0;
      read_pend_q         <= 1'b0;
    end
    else
    begin
      read_pend_q <= rd_fault;
      if (normal_mode && temp_over)
        temp_prewarn_flag_q <= 1'b1;                // R10
      else if (read_pend_q && !temp_over)
        temp_prewarn_flag_q <= 1'b0;                // R11 R15
    end
  end

  // ************************************************************
  // interrupt status, write one to clear, set wins
  // ************************************************************
  wire [IRQ_WIDTH-1:0] irq_ev;
  assign irq_ev[IRQ_PREWARN_BIT] = normal_mode && temp_over && !temp_prewarn_flag_q;
  assign irq_ev[IRQ_VALID_BIT]   = (st_d == ST_VALID) && (st_q == ST_SETTLE);
  assign irq_ev[IRQ_HOLD_BIT]    = (st_d == ST_HOLD) && (st_q == ST_VALID);
  wire [IRQ_WIDTH-1:0] irq_clr = wr_stat ? reg_wdata[IRQ_WIDTH-1:0] : '0;
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      irq_status_q <= '0;
      irq          <= 1'b0;
    end
    else
    begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_ev;
      // a mask bit at one blocks its source, so the reset value leaves all sources live
      irq          <= |(((irq_status_q & ~irq_clr) | irq_ev) & ~irq_mask_q);
    end
  end

  // ************************************************************
  // read data, one cycle after the strobe
  // ************************************************************
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0000;
    case (reg_addr)
      ADDR_GENERAL_CONFIG: rd_mux = general_config_reg_q;
      ADDR_RETRY_CONFIG:   rd_mux[RETRY_OFFSET_BIT] = channel_offset_polarity_q[ch_idx];
      ADDR_FAULT_REPORT:   rd_mux[FAULT_PREWARN_BIT] = temp_prewarn_flag_q;
      ADDR_CHANNEL_STATE:  rd_mux[1:0] = chan_state;   // R12
      ADDR_IRQ_STATUS:     rd_mux[IRQ_WIDTH-1:0] = irq_status_q;
      ADDR_IRQ_MASK:       rd_mux[IRQ_WIDTH-1:0] = irq_mask_q;
      default:             rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end
endmodule : cssc_top

// File: rtl/cssc_pkg.sv
// package of constants for the current sense status and control block
package cssc_pkg;
  // ************************************************************
  // register indices (plain port, word addressed)
  // ************************************************************
  localparam logic [3:0] ADDR_GENERAL_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_RETRY_CONFIG   = 4'h1;
  localparam logic [3:0] ADDR_FAULT_REPORT   = 4'h2;
  localparam logic [3:0] ADDR_CHANNEL_STATE  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS     = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK       = 4'h5;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int GCR_SENSE_LO_BIT   = 1;
  localparam int GCR_SENSE_HI_BIT   = 2;
  localparam int GCR_TRACK_HOLD_BIT = 5;
  localparam int RETRY_OFFSET_BIT   = 8;
  localparam int FAULT_PREWARN_BIT  = 8;
  localparam int IRQ_PREWARN_BIT    = 0;
  localparam int IRQ_VALID_BIT      = 1;
  localparam int IRQ_HOLD_BIT       = 2;
  localparam int IRQ_WIDTH          = 3;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] GENERAL_CONFIG_RST = 16'h0000;
  localparam logic [15:0] RETRY_CONFIG_RST   = 16'h0000;
  localparam logic [2:0]  IRQ_MASK_RST       = 3'h0;
  // ************************************************************
  // timing: settling time after turn-on before sense is valid
  // ************************************************************
  localparam int SETTLE_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISCHARGE_CYCLES = 2;
  // sense source select encoding {hi, lo}
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_CH0  = 2'h1;
  localparam logic [1:0] SRC_CH1  = 2'h2;
  localparam logic [1:0] SRC_TEMP = 2'h3;
  // sense path state
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_VALID, ST_HOLD} cssc_sense_e;
endpackage : cssc_pkg

// File: rtl/cssc_sync.sv
// two-flop level synchroniser, one per bit
`timescale 1ns/10ps
module cssc_sync
  import cssc_pkg::*;
#(
  parameter int WIDTH = 3
)(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage read only by the second stage
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge sys_clk)
      begin
        if (!resetn)
        begin
          meta_q[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule : cssc_sync

// File: bench/cssc_sva.sv
// assertion checker for the current sense control block
`timescale 1ns/10ps
module cssc_sva
  import cssc_pkg::*;
#(
  parameter int SENSE_W = 10
)(
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               resetn,
  // register port
  input wire logic [3:0]         reg_addr,
  input wire logic [15:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_rdata,
  // comparator levels
  input wire logic [1:0]         out_above_half,
  input wire logic               temp_above_prewarn,
  input wire logic               normal_mode,
  // sense outputs
  input wire logic [SENSE_W-1:0] sense_out,
  input wire logic               sense_drive,
  input wire logic               sense_sync,
  input wire logic               irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ************************************************************
  // register port
  // ************************************************************
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  unmapped_zero_a: assert property (reg_rd && reg_addr > ADDR_IRQ_MASK |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
  chan_state_a: assert property ($stable(out_above_half)[*4] ##0 reg_rd && reg_addr == ADDR_CHANNEL_STATE
    |=> reg_rdata[1:0] == $past(out_above_half))
    else $error("channel state bits do not follow outputs");
  prewarn_set_a: assert property ((normal_mode && temp_above_prewarn)[*4] ##1 reg_rd && reg_addr == ADDR_FAULT_REPORT
    |=> reg_rdata[FAULT_PREWARN_BIT])
    else $error("prewarning flag not set");
  // ************************************************************
  // sense path and interrupt mask
  // ************************************************************
  valid_driven_a: assert property (!sense_drive |-> sense_sync)
    else $error("sense marked valid while not driven");
  settle_gap_a: assert property ($fell(sense_sync) |-> $past(sense_drive, 8))
    else $error("sense marked valid before settling");
  hold_stable_a: assert property ($rose(sense_sync) && sense_drive |=> sense_drive && $stable(sense_out))
    else $error("held sense value not kept");
  off_zero_a: assert property (!sense_drive |-> sense_out == '0)
    else $error("sense value present while not driven");
  mask_quiet_a: assert property (reg_wr && reg_addr == ADDR_IRQ_MASK && reg_wdata[2:0] == 3'h7 |=> ##1 !irq)
    else $error("interrupt high with all sources masked");
  // main scenarios reached
  cover property ($fell(sense_sync));
  cover property ($rose(sense_sync) && sense_drive);
  cover property ($rose(irq));
endmodule : cssc_sva

bind cssc_top cssc_sva #(.SENSE_W(SENSE_W)) u_sva (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_above_half(out_above_half),
  .temp_above_prewarn(temp_above_prewarn), .normal_mode(normal_mode), .sense_out(sense_out),
  .sense_drive(sense_drive), .sense_sync(sense_sync), .irq(irq));

// File: bench/cssc_switch_model.sv
// model of the switch stage: output levels follow the on command after a slew delay
`timescale 1ns/10ps
module cssc_switch_model (
  // clock
  input  wire logic       sys_clk,
  // command and comparator level
  input  wire logic [1:0] chan_on_cmd,
  output logic      [1:0] out_above_half
);
  logic [5:0] slew_q = 6'h00;
  // three cycle slew, so the state bits lag the command as a real output would
  always @(posedge sys_clk)
    slew_q <= {slew_q[3:0], chan_on_cmd};
  assign out_above_half = slew_q[5:4];
endmodule : cssc_switch_model

// File: bench/tb_top.sv
// self-checking bench for the current sense control block
`timescale 1ns/10ps
module tb_top;
  import cssc_pkg::*;
  logic        sys_clk, resetn, reg_wr, reg_rd, temp_above_prewarn, normal_mode;
  logic        sense_drive, sense_sync, irq;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0]  chan_on_cmd, out_above_half;
  logic [9:0]  chan0_sense, chan1_sense, temp_sense, chan0_offset, chan1_offset, sense_out;
  int          failures, check_count;
  cssc_top uut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_on_cmd(chan_on_cmd),
    .out_above_half(out_above_half), .temp_above_prewarn(temp_above_prewarn), .normal_mode(normal_mode),
    .chan0_sense(chan0_sense), .chan1_sense(chan1_sense), .temp_sense(temp_sense),
    .chan0_offset(chan0_offset), .chan1_offset(chan1_offset), .sense_out(sense_out),
    .sense_drive(sense_drive), .sense_sync(sense_sync), .irq(irq));
  cssc_switch_model u_sw (.sys_clk(sys_clk), .chan_on_cmd(chan_on_cmd), .out_above_half(out_above_half));
  // ************************************************************
  // clock, watchdog and closing
  // ************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // the whole run needs under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // ************************************************************
  // access tasks
  // ************************************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    if (g !== e)
      failures++;
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic on(input logic [1:0] c);
    @(posedge sys_clk);
    chan_on_cmd <= c;
  endtask : on
  task automatic wait_valid();
    int n;
    n = 0;
    while (sense_sync !== 1'b0 && n < 40)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk({15'h0000, sense_sync}, 16'h0000);
  endtask : wait_valid
  // irq is looked at after the edge that launches it has settled
  task automatic chk_irq(input logic e);
    #1 chk({15'h0000, irq}, {15'h0000, e});
  endtask : chk_irq
  task automatic chk_sense(input logic d, input logic [9:0] e);
    #1 chk({5'h00, sense_drive, sense_out}, {5'h00, d, e});
  endtask : chk_sense
  // ************************************************************
  // test sequence
  // ************************************************************
  initial
  begin
    {resetn, reg_wr, reg_rd, temp_above_prewarn, normal_mode} = 5'h00;
    {reg_addr, reg_wdata, chan_on_cmd} = 22'h000000;
    {chan0_sense, chan0_offset, chan1_sense, chan1_offset} = {10'h100, 10'h010, 10'h080, 10'h008};
    temp_sense = 10'h055;
    tick(5);
    resetn <= 1'b1;
    rd(ADDR_GENERAL_CONFIG, GENERAL_CONFIG_RST);
    rd(ADDR_RETRY_CONFIG, RETRY_CONFIG_RST);
    rd(ADDR_IRQ_MASK, {13'h0000, IRQ_MASK_RST});
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    // channel state follows each output in turn
    on(2'h1);
    tick(6);
    rd(ADDR_CHANNEL_STATE, 16'h0001);
    on(2'h3);
    tick(6);
    rd(ADDR_CHANNEL_STATE, 16'h0003);
    on(2'h0);
    tick(6);
    rd(ADDR_CHANNEL_STATE, 16'h0000);
    // synchronous sensing, channel 0 with both offset polarities, then channel 1
    wr(ADDR_GENERAL_CONFIG, 16'h0002);
    on(2'h1);
    wait_valid();
    chk_sense(1'b1, 10'h0F0);
    wr(ADDR_RETRY_CONFIG, 16'h0100);
    rd(ADDR_RETRY_CONFIG, 16'h0100);
    tick(3);
    chk_sense(1'b1, 10'h110);
    on(2'h0);
    tick(3);
    chk_sense(1'b0, 10'h000);
    wr(ADDR_GENERAL_CONFIG, 16'h0004);
    on(2'h2);
    wait_valid();
    chk_sense(1'b1, 10'h078);
    on(2'h0);
    tick(3);
    // track and hold on channel 0, polarity changed while off
    wr(ADDR_GENERAL_CONFIG, 16'h0022);
    on(2'h1);
    wait_valid();
    on(2'h0);
    tick(3);
    chk_sense(1'b1, 10'h110);
    chk({15'h0000, sense_sync}, 16'h0001);
    wr(ADDR_RETRY_CONFIG, 16'h0000);
    chan0_sense <= 10'h1FF;
    tick(3);
    chk_sense(1'b1, 10'h110);
    // second measurement after one on period with opposite polarity, settled first
    tick(1);
    chan0_sense <= 10'h100;
    on(2'h1);
    wait_valid();
    tick(5);
    on(2'h0);
    tick(3);
    chk_sense(1'b1, 10'h0F0);
    // selecting channel 1 while it is off loses the held value
    wr(ADDR_GENERAL_CONFIG, 16'h0024);
    tick(4);
    chk_sense(1'b0, 10'h000);
    // temperature as sense source is driven whatever the channels do
    wr(ADDR_GENERAL_CONFIG, 16'h0006);
    tick(3);
    chk_sense(1'b1, 10'h055);
    // valid and hold events left sticky bits behind
    rd(ADDR_IRQ_STATUS, 16'h0006);
    // prewarning flag, sticky status and interrupt
    wr(ADDR_IRQ_STATUS, 16'h0007);
    tick(2);
    chk_irq(1'b0);
    tick(1);
    temp_above_prewarn <= 1'b1;
    tick(6);
    rd(ADDR_FAULT_REPORT, 16'h0000);
    tick(1);
    normal_mode <= 1'b1;
    tick(6);
    chk_irq(1'b1);
    rd(ADDR_FAULT_REPORT, 16'h0100);
    tick(2);
    rd(ADDR_FAULT_REPORT, 16'h0100);
    tick(1);
    temp_above_prewarn <= 1'b0;
    tick(6);
    rd(ADDR_FAULT_REPORT, 16'h0100);
    tick(2);
    rd(ADDR_FAULT_REPORT, 16'h0000);
    rd(ADDR_IRQ_STATUS, 16'h0001);
    wr(ADDR_IRQ_MASK, 16'h0007);
    tick(2);
    chk_irq(1'b0);
    wr(ADDR_IRQ_MASK, 16'h0000);
    tick(2);
    chk_irq(1'b1);
    wr(ADDR_IRQ_STATUS, 16'h0001);
    tick(2);
    chk_irq(1'b0);
    report_and_stop();
  end
endmodule : tb_top
